/* File: src/dcsr_consts.vh */
// constants for the debugger control and status register block
`ifndef DCSR_CONSTS_VH
`define DCSR_CONSTS_VH

// command bytes
`define DCSR_CMD_RD_STAT 8'h02
`define DCSR_CMD_WR_CTL 8'h04
`define DCSR_CMD_RD_CTL 8'h05

// control register fields
`define DCSR_CTL_DEBUG 7
`define DCSR_CTL_BREAK_ENA 6
`define DCSR_CTL_ACKEN 5
`define DCSR_CTL_LOOP 4
`define DCSR_CTL_PCMATCH 3
`define DCSR_CTL_ZERO 2
`define DCSR_CTL_RSV 1
`define DCSR_CTL_RST 0

// status register fields
`define DCSR_STAT_IDLE 7
`define DCSR_STAT_HALT 6
`define DCSR_STAT_PROT 5

// reset values and special bytes
`define DCSR_CTL_RESET 8'h00
`define DCSR_STAT_RESET 8'h00
`define DCSR_ACK_BYTE 8'hFF
`define DCSR_BREAK_OPCODE 8'h00
`define DCSR_CNT_ZERO 16'h0000
`define DCSR_CNT_INIT 16'h0000

`endif

/* File: src/dcsr_counter.v */
// debug counter: down counter or program counter comparator
`timescale 1ns/1ns
`default_nettype none

module dcsr_counter #(
	parameter WIDTH = 16
) (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// control
	input wire loadEn,
	input wire [WIDTH-1:0] loadVal,
	input wire countEn,
	input wire reinit,
	input wire [WIDTH-1:0] pcVal,
	// results
	output reg [WIDTH-1:0] cntVal_ff,
	output reg zeroHit_ff,
	output reg pcHit_ff
);
	reg [WIDTH-1:0] nxt_cntVal;

	always @* begin
		nxt_cntVal = cntVal_ff;
		if (loadEn) begin
			nxt_cntVal = loadVal;
		end else if (reinit) begin
			nxt_cntVal = {WIDTH{1'b0}};
		end else if (countEn) begin
			nxt_cntVal = cntVal_ff - {{(WIDTH-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cntVal_ff <= {WIDTH{1'b0}};
			zeroHit_ff <= 1'b0;
			pcHit_ff <= 1'b0;
		end else begin
			cntVal_ff <= nxt_cntVal;
			// only a decrement landing on zero counts as a hit
			zeroHit_ff <= countEn && !loadEn && !reinit &&
				(nxt_cntVal == {WIDTH{1'b0}});
			pcHit_ff <= (pcVal == cntVal_ff);
		end
	end
endmodule // dcsr_counter

`default_nettype wire

/* File: src/dcsr_top.v */
// debugger control and status registers with command port
`timescale 1ns/1ns
`default_nettype none
`include "dcsr_consts.vh"

// What this block does
// - writing one to bit 7 enters debug mode, cpu stops fetching
// - clearing bit 7 lets the cpu resume where it stopped
// - with read protection, bit 7 cannot be written to zero
// - breakpoint enable bit 6 low makes the break opcode a no-op
// - enabled break with loop-select low sets debug mode
// - enabled break with loop-select high loops cpu on the break
// - acknowledge enable bit 5 sends FFH to host on every breakpoint
// - pc-match bit 3 sets debug mode when pc equals counter
// - pc-match set holds counter while running; otherwise it counts
// - zero-break bit 2 sets debug mode when counter reaches zero
// - zero-break set keeps counter value when leaving debug mode
// - reset bit 0 resets device, debugger keeps its state
// - reset bit clears itself once the triggered reset completes
// - writing 81H resets and leaves device stopped in debug mode
// - writing 41H resets and runs with breakpoints enabled
// - in debug mode writing 40H resumes with breakpoints enabled
// - stopped flag shows debug mode or break since last control write
// - halt flag shows the device halt mode
// - read-protect flag is one when the stored option bit is zero
// - command 04H plus one data byte loads the control register
// - command 05H returns control, 02H returns status
module dcsr_top #(
	parameter CNT_WIDTH = 16
) (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// byte stream from the host receiver
	input wire rxValid,
	input wire [7:0] rxByte,
	// byte stream to the host transmitter
	output reg txValid_ff,
	output reg [7:0] txByte_ff,
	// cpu side
	input wire brkDecoded,
	input wire [CNT_WIDTH-1:0] pcVal,
	input wire cpuHalted,
	input wire rpOptionBit,
	input wire sysResetDone,
	// counter load from the host command decoder
	input wire cntLoad,
	input wire [CNT_WIDTH-1:0] cntLoadVal,
	// outputs to the cpu and reset logic
	output reg stopFetch_ff,
	output reg loop_select_bit_ff,
	output reg sysResetReq_ff,
	output reg brkNop_ff,
	output reg [CNT_WIDTH-1:0] cntOut_ff
);

	// ---------------------------------------------------------------
	// command parser states
	// ---------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_DATA = 2'b10;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [7:0] ctl_ff;
	reg [7:0] nxt_ctl;
	reg brkSeen_ff;
	reg nxt_brkSeen;
	reg ctlWrite;
	reg [7:0] wrData;
	reg ackPend_ff;
	reg nxt_ackPend;
	reg rdReq;
	reg [7:0] rdData;
	reg rstIssued_ff;
	reg nxt_rstIssued;

	wire [CNT_WIDTH-1:0] cntVal;
	wire zeroHit;
	wire pcHit;
	wire readProt;
	wire brkTaken;
	wire breakEvent;
	wire leaveDebug;
	wire [7:0] statVal;

	// option stored as zero means protection on
	assign readProt = !rpOptionBit;

	// break opcode only acts when enabled
	assign brkTaken = brkDecoded && ctl_ff[`DCSR_CTL_BREAK_ENA];

	// any cause that forces debug mode
	assign breakEvent = (brkTaken && !ctl_ff[`DCSR_CTL_LOOP]) ||
		(pcHit && ctl_ff[`DCSR_CTL_PCMATCH]) ||
		(zeroHit && ctl_ff[`DCSR_CTL_ZERO]);

	assign leaveDebug = ctl_ff[`DCSR_CTL_DEBUG] &&
		!nxt_ctl[`DCSR_CTL_DEBUG];

	// reserved status bits forced to zero
	assign statVal = {ctl_ff[`DCSR_CTL_DEBUG] || brkSeen_ff,
		cpuHalted, readProt, 5'h00};

	// ---------------------------------------------------------------
	// debug counter
	// ---------------------------------------------------------------
	// counts only while running, and never in pc-match mode
	dcsr_counter #(
		.WIDTH(CNT_WIDTH)
	) u_counter (
		.mclk(mclk),
		.arst_n(arst_n),
		.loadEn(cntLoad && ctl_ff[`DCSR_CTL_DEBUG]),
		.loadVal(cntLoadVal),
		.countEn(!ctl_ff[`DCSR_CTL_DEBUG] &&
			!ctl_ff[`DCSR_CTL_PCMATCH]),
		// the zero-break bit being written decides, not the old one
		.reinit(leaveDebug && !nxt_ctl[`DCSR_CTL_ZERO]),
		.pcVal(pcVal),
		.cntVal_ff(cntVal),
		.zeroHit_ff(zeroHit),
		.pcHit_ff(pcHit)
	);

	// ---------------------------------------------------------------
	// command parser
	// ---------------------------------------------------------------
	always @* begin
		nxt_state = state_ff;
		ctlWrite = 1'b0;
		wrData = 8'h00;
		rdReq = 1'b0;
		rdData = 8'h00;
		case (state_ff)
			ST_IDLE: begin
				if (rxValid) begin
					if (rxByte == `DCSR_CMD_WR_CTL) begin
						nxt_state = ST_DATA;
					end else if (rxByte == `DCSR_CMD_RD_CTL) begin
						rdReq = 1'b1;
						rdData = ctl_ff;
					end else if (rxByte == `DCSR_CMD_RD_STAT) begin
						rdReq = 1'b1;
						rdData = statVal;
					end
				end
			end
			ST_DATA: begin
				if (rxValid) begin
					ctlWrite = 1'b1;
					wrData = rxByte;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	always @* begin
		nxt_ctl = ctl_ff;
		nxt_rstIssued = rstIssued_ff;
		if (ctlWrite) begin
			nxt_ctl = wrData;
			// reserved bit kept zero whatever the host sends
			nxt_ctl[`DCSR_CTL_RSV] = 1'b0;
			if (readProt && ctl_ff[`DCSR_CTL_DEBUG]) begin
				nxt_ctl[`DCSR_CTL_DEBUG] = 1'b1;
			end
			if (wrData[`DCSR_CTL_RST]) begin
				nxt_rstIssued = 1'b0;
			end
		end
		// hardware set wins over a host clear
		if (breakEvent) begin
			nxt_ctl[`DCSR_CTL_DEBUG] = 1'b1;
		end
		if (ctl_ff[`DCSR_CTL_RST] && !ctlWrite) begin
			if (!rstIssued_ff) begin
				nxt_rstIssued = 1'b1;
			end else if (sysResetDone) begin
				nxt_ctl[`DCSR_CTL_RST] = 1'b0;
				nxt_rstIssued = 1'b0;
			end
		end
	end

	// stopped flag: cleared by a control write unless a break lands
	always @* begin
		nxt_brkSeen = brkSeen_ff;
		if (ctlWrite) begin
			nxt_brkSeen = 1'b0;
		end
		if (brkTaken) begin
			nxt_brkSeen = 1'b1;
		end
	end

	// ack byte waits if a read answer holds the transmitter
	always @* begin
		nxt_ackPend = ackPend_ff;
		if (!rdReq) begin
			nxt_ackPend = 1'b0;
		end
		if ((brkTaken || breakEvent) && ctl_ff[`DCSR_CTL_ACKEN]) begin
			nxt_ackPend = 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
			ctl_ff <= `DCSR_CTL_RESET;
			brkSeen_ff <= 1'b0;
			ackPend_ff <= 1'b0;
			rstIssued_ff <= 1'b0;
			txValid_ff <= 1'b0;
			txByte_ff <= 8'h00;
			stopFetch_ff <= 1'b0;
			loop_select_bit_ff <= 1'b0;
			sysResetReq_ff <= 1'b0;
			brkNop_ff <= 1'b1;
			cntOut_ff <= `DCSR_CNT_INIT;
		end else begin
			state_ff <= nxt_state;
			ctl_ff <= nxt_ctl;
			brkSeen_ff <= nxt_brkSeen;
			ackPend_ff <= nxt_ackPend;
			rstIssued_ff <= nxt_rstIssued;
			if (rdReq) begin
				txValid_ff <= 1'b1;
				txByte_ff <= rdData;
			end else if (ackPend_ff) begin
				txValid_ff <= 1'b1;
				txByte_ff <= `DCSR_ACK_BYTE;
			end else begin
				txValid_ff <= 1'b0;
				txByte_ff <= 8'h00;
			end
			stopFetch_ff <= nxt_ctl[`DCSR_CTL_DEBUG];
			loop_select_bit_ff <= brkTaken && ctl_ff[`DCSR_CTL_LOOP];
			brkNop_ff <= !nxt_ctl[`DCSR_CTL_BREAK_ENA];
			// system reset leaves this block's state untouched
			sysResetReq_ff <= nxt_ctl[`DCSR_CTL_RST];
			cntOut_ff <= cntVal;
		end
	end
endmodule // dcsr_top

`default_nettype wire

/* File: verif/dcsr_checker.sv */
// assertion checker for the debugger register block
`timescale 1ns/1ns
`default_nettype none
module dcsr_checker (
	// clock and reset
	input wire mclk,
	input wire arst_n,
	// host bytes
	input wire rxValid,
	input wire [7:0] rxByte,
	input wire txValid_ff,
	input wire [7:0] txByte_ff,
	// cpu side
	input wire brkDecoded,
	input wire cpuHalted,
	input wire rpOptionBit,
	input wire sysResetDone,
	input wire stopFetch_ff,
	input wire loop_select_bit_ff,
	input wire sysResetReq_ff
);
	// marks that the next host byte is write data, not a command
	reg dataNext_ff;
	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n)
			dataNext_ff <= 1'b0;
		else if (rxValid)
			dataNext_ff <= !dataNext_ff && rxByte == 8'h04;
	end
	wire cmdIn = rxValid && !dataNext_ff;
	wire dataIn = rxValid && dataNext_ff;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	chk_read_answer: assert property (
		cmdIn && (rxByte == 8'h05 || rxByte == 8'h02) |=> txValid_ff)
		else $error("no read answer");
	chk_stat_bits: assert property (
		cmdIn && rxByte == 8'h02 |=> txByte_ff[6:0] ==
		{$past(cpuHalted), !$past(rpOptionBit), 5'h00})
		else $error("bad status bits");
	chk_enter_debug: assert property (
		dataIn && rxByte[7] |-> ##[1:2] stopFetch_ff)
		else $error("debug mode not entered");
	chk_reset_req: assert property (
		dataIn && rxByte[0] |-> ##[1:2] sysResetReq_ff)
		else $error("no reset request");
	chk_reset_clear: assert property (
		sysResetReq_ff [*2] ##0 sysResetDone |-> ##[1:3] !sysResetReq_ff)
		else $error("reset bit not cleared");
	chk_protect_hold: assert property (
		!rpOptionBit && stopFetch_ff |=> stopFetch_ff)
		else $error("protected debug mode left");
	chk_resume_cause: assert property (
		$fell(stopFetch_ff) |-> $past(dataIn) || $past(dataIn, 2))
		else $error("resume without write");
	chk_loop_cause: assert property (
		loop_select_bit_ff |-> $past(brkDecoded))
		else $error("loop without break");
endmodule // dcsr_checker
bind dcsr_top dcsr_checker u_chk (.mclk(mclk), .arst_n(arst_n),
	.rxValid(rxValid), .rxByte(rxByte), .txValid_ff(txValid_ff),
	.txByte_ff(txByte_ff), .brkDecoded(brkDecoded), .cpuHalted(cpuHalted),
	.rpOptionBit(rpOptionBit), .sysResetDone(sysResetDone),
	.stopFetch_ff(stopFetch_ff), .loop_select_bit_ff(loop_select_bit_ff),
	.sysResetReq_ff(sysResetReq_ff));
`default_nettype wire

/* File: verif/dcsr_host.sv */
// host debugger model: sends bytes, counts acknowledge bytes
`timescale 1ns/1ns
`default_nettype none
module dcsr_host (
	// clock
	input wire mclk,
	// byte streams
	output logic rxValid,
	output logic [7:0] rxByte,
	input wire txValid_ff,
	input wire [7:0] txByte_ff
);
	int nAck = 0;
	initial begin
		rxValid = 1'b0;
		rxByte = 8'h00;
	end
	// idle byte is inverted so a stale byte never looks right
	task send(input logic [7:0] b);
		@(posedge mclk);
		rxValid <= 1'b1;
		rxByte <= b;
		@(posedge mclk);
		rxValid <= 1'b0;
		rxByte <= ~b;
	endtask
	always @(posedge mclk) begin
		if (txValid_ff === 1'b1 && txByte_ff === 8'hFF)
			nAck <= nAck + 1;
	end
endmodule // dcsr_host
`default_nettype wire

/* File: verif/tb.sv */
// self-checking bench for the debugger register block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checksDone++; if ((s) !== (e)) begin \
	$display("MISMATCH %s exp %h got %h", n, e, s); nMismatch++; end end
module tb;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic brkDecoded = 1'b0;
	logic cpuHalted = 1'b0;
	logic rpOptionBit = 1'b1;
	logic sysResetDone = 1'b0;
	logic [15:0] pcVal = 16'h1234;
	logic cntLoad = 1'b0;
	logic [15:0] cntLoadVal = 16'h0000;
	wire rxValid, txValid_ff, stopFetch_ff, loop_select_bit_ff, sysResetReq_ff;
	wire brkNop_ff;
	wire [7:0] rxByte, txByte_ff;
	wire [15:0] cntOut_ff;
	int nMismatch = 0;
	int checksDone = 0;
	dcsr_host host (.mclk(mclk), .rxValid(rxValid), .rxByte(rxByte),
		.txValid_ff(txValid_ff), .txByte_ff(txByte_ff));
	dcsr_top DUT (.mclk(mclk), .arst_n(arst_n), .rxValid(rxValid),
		.rxByte(rxByte), .txValid_ff(txValid_ff), .txByte_ff(txByte_ff),
		.brkDecoded(brkDecoded), .pcVal(pcVal), .cpuHalted(cpuHalted),
		.rpOptionBit(rpOptionBit), .sysResetDone(sysResetDone),
		.cntLoad(cntLoad), .cntLoadVal(cntLoadVal),
		.stopFetch_ff(stopFetch_ff),
		.loop_select_bit_ff(loop_select_bit_ff), .sysResetReq_ff(sysResetReq_ff),
		.brkNop_ff(brkNop_ff), .cntOut_ff(cntOut_ff));
	initial forever #10 mclk = ~mclk;
	task endOfTest;
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task wr(input logic [7:0] d);
		host.send(8'h04);
		host.send(d);
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task rd(input logic [7:0] c, input logic [7:0] e, input string n);
		host.send(c);
		#1;
		`CHK(n, 1'b1, txValid_ff)
		`CHK(n, e, txByte_ff)
	endtask
	task waitStop(input logic e);
		int i;
		for (i = 0; i < 8 && stopFetch_ff !== e; i++) begin
			@(posedge mclk);
			#1;
		end
		`CHK("stop", e, stopFetch_ff)
		if (i == 8)
			endOfTest;
	endtask
	task pulseBreak;
		@(posedge mclk) brkDecoded <= 1'b1;
		@(posedge mclk) brkDecoded <= 1'b0;
		#1;
	endtask
	task tStopGo;
		`CHK("nop", 1'b1, brkNop_ff)
		rd(8'h05, 8'h00, "ctl");
		rd(8'h02, 8'h00, "stat");
		wr(8'h81);
		`CHK("rstReq", 1'b1, sysResetReq_ff)
		waitStop(1'b1);
		@(posedge mclk) sysResetDone <= 1'b1;
		@(posedge mclk) sysResetDone <= 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		`CHK("rstReq", 1'b0, sysResetReq_ff)
		rd(8'h05, 8'h80, "ctl");
		rd(8'h02, 8'h80, "stat");
		wr(8'h40);
		waitStop(1'b0);
		`CHK("nop", 1'b0, brkNop_ff)
		$display("test stop and go ended");
	endtask
	task tBreak;
		wr(8'h60);
		pulseBreak;
		waitStop(1'b1);
		repeat (3) @(posedge mclk);
		`CHK("ack", 1, host.nAck)
		wr(8'h50);
		pulseBreak;
		`CHK("loop", 1'b1, loop_select_bit_ff)
		waitStop(1'b0);
		rd(8'h02, 8'h80, "stat");
		wr(8'h00);
		pulseBreak;
		`CHK("loop", 1'b0, loop_select_bit_ff)
		waitStop(1'b0);
		`CHK("ack", 1, host.nAck)
		$display("test break ended");
	endtask
	task tCounter;
		wr(8'h80);
		@(posedge mclk) begin
			cntLoad <= 1'b1;
			cntLoadVal <= 16'h0040;
		end
		@(posedge mclk) cntLoad <= 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		`CHK("cnt", 16'h0040, cntOut_ff)
		wr(8'h08);
		repeat (4) @(posedge mclk);
		#1;
		`CHK("cnt", 16'h0000, cntOut_ff)
		`CHK("stop", 1'b0, stopFetch_ff)
		@(posedge mclk) pcVal <= 16'h0000;
		waitStop(1'b1);
		@(posedge mclk) begin
			pcVal <= 16'h1234;
			cntLoad <= 1'b1;
			cntLoadVal <= 16'h0003;
		end
		@(posedge mclk) cntLoad <= 1'b0;
		wr(8'h04);
		waitStop(1'b1);
		wr(8'h41);
		`CHK("stop", 1'b0, stopFetch_ff)
		`CHK("rstReq", 1'b1, sysResetReq_ff)
		`CHK("nop", 1'b0, brkNop_ff)
		@(posedge mclk) sysResetDone <= 1'b1;
		@(posedge mclk) sysResetDone <= 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		`CHK("rstReq", 1'b0, sysResetReq_ff)
		rd(8'h05, 8'h40, "ctl");
		$display("test counter ended");
	endtask
	task tProtect;
		@(posedge mclk) begin
			rpOptionBit <= 1'b0;
			cpuHalted <= 1'b1;
		end
		wr(8'h80);
		wr(8'h00);
		`CHK("stop", 1'b1, stopFetch_ff)
		rd(8'h02, 8'hE0, "stat");
		@(posedge mclk) arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		rpOptionBit <= 1'b1;
		#1;
		`CHK("stop", 1'b0, stopFetch_ff)
		$display("test protect ended");
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		tStopGo;
		tBreak;
		tCounter;
		tProtect;
		endOfTest;
	end
endmodule // tb
`default_nettype wire
